// [src/programmable_period_pwm.sv]
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "pwm_map.svh"
// Contract
// - 16-bit prescaler, 8-bit counter, width, period
// - counter rate is half clock over divider+1
// - divider zero ticks every half-rate clock
// - free counter compared to comparator copies
// - enabling copies registers into comparators first
// - normal polarity: low once count reaches width
// - count equals period: clear, drive high
// - new values load only at period end
// - control bits 5 and 6 govern channel
// - output goes to port 4 bit 7
// - registers at aah, abh, b3h, b4h
// - control bit 6 selects polarity
// - control bit 5 enables output
// - control bit 4: open drain or push-pull
module programmable_period_pwm
    import pwm_pkg::*;
#(
    parameter int CNT_W = 8,
    parameter int DIV_W = 16
) (
    // clock, reset, enable
    input  wire logic        core_clk_in,
    input  wire logic        reset_in,
    input  wire logic        clk_en_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // port 4 bit 7 pin
    output logic             p4_7_out,
    output logic             p4_7_oe_out
);
    ch_state_t        state_r;
    logic [7:0]       ctrl_r;
    logic [CNT_W-1:0] period_r;
    logic [CNT_W-1:0] width_r;
    logic [DIV_W-1:0] div_r;
    logic [CNT_W-1:0] cmp_period_r;
    logic [CNT_W-1:0] cmp_width_r;
    logic [CNT_W-1:0] count_r;
    logic             wave_r;
    logic             tick;
    logic             reload;
    logic             period_end;
    logic             enabled;
    logic [9:0]       word_idx;
    logic             hit_ctrl;
    logic             hit_period;
    logic             hit_width;
    logic             hit_lo;
    logic             hit_hi;
    logic             hit_any;
    logic             wr_acc;
    logic             rd_acc;
    logic [7:0]       rd_byte;

    // apb decode: one word per printed index
    assign word_idx   = paddr_in[11:`ADDR_SHIFT];
    assign hit_ctrl   = (word_idx == 10'(`IDX_CTRL));
    assign hit_period = (word_idx == 10'(`IDX_PERIOD));
    assign hit_width  = (word_idx == 10'(`IDX_WIDTH));
    assign hit_lo     = (word_idx == 10'(`IDX_DIV_LO));
    assign hit_hi     = (word_idx == 10'(`IDX_DIV_HI));
    assign hit_any    = hit_ctrl | hit_period | hit_width | hit_lo | hit_hi;
    // answer after one wait state; pready is a flop so it rises one cycle after the first access cycle
    assign wr_acc     = psel_in && penable_in && pwrite_in && pready_out;
    assign rd_acc     = psel_in && penable_in && !pwrite_in;

    always_comb begin
        rd_byte = `RST_BYTE;
        if (hit_ctrl) begin
            rd_byte = ctrl_r;
        end else if (hit_period) begin
            rd_byte = period_r;
        end else if (hit_width) begin
            rd_byte = width_r;
        end else if (hit_lo) begin
            rd_byte = div_r[7:0];
        end else if (hit_hi) begin
            rd_byte = div_r[15:8];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else if (clk_en_in) begin
            pready_out  <= psel_in && penable_in && !pready_out;
            pslverr_out <= psel_in && penable_in && !pready_out && !hit_any;
            if (rd_acc && !pready_out) begin
                prdata_out <= {24'h00_0000, rd_byte};
            end
        end
    end

    // software registers
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            ctrl_r   <= `RST_BYTE;
            period_r <= CNT_W'(`RST_BYTE);
            width_r  <= CNT_W'(`RST_BYTE);
            div_r    <= DIV_W'(`RST_DIV);
        end else if (clk_en_in && wr_acc) begin
            if (hit_ctrl) begin
                ctrl_r <= pwdata_in[7:0];
            end
            if (hit_period) begin
                period_r <= pwdata_in[CNT_W-1:0];
            end
            if (hit_width) begin
                width_r <= pwdata_in[CNT_W-1:0];
            end
            if (hit_lo) begin
                div_r[7:0] <= pwdata_in[7:0];
            end
            if (hit_hi) begin
                div_r[15:8] <= pwdata_in[7:0];
            end
        end
    end

    assign enabled    = ctrl_r[`CTRL_EN_BIT];
    // a period of zero is outside the contract; it then ends every tick
    assign period_end = tick && (count_r == cmp_period_r);
    // reload on the enable edge and at each period end
    assign reload     = (state_r == CH_IDLE && enabled) || period_end;

    half_rate_divider #(
        .DIV_W(DIV_W)
    ) i_half_rate_divider (
        .core_clk_in(core_clk_in),
        .reset_in   (reset_in),
        .clk_en_in  (clk_en_in),
        .run_in     (state_r == CH_RUN && enabled),
        .reload_in  (reload),
        .div_in     (div_r),
        .tick_out   (tick)
    );

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            state_r <= CH_IDLE;
        end else if (clk_en_in) begin
            case (state_r)
                CH_IDLE: begin
                    if (enabled) begin
                        state_r <= CH_RUN;
                    end
                end
                CH_RUN: begin
                    if (!enabled) begin
                        state_r <= CH_IDLE;
                    end
                end
                default: state_r <= CH_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            cmp_period_r <= CNT_W'(`RST_BYTE);
            cmp_width_r  <= CNT_W'(`RST_BYTE);
        end else if (clk_en_in && reload) begin
            cmp_period_r <= period_r;
            cmp_width_r  <= width_r;
        end
    end

    // idle and disable clears are gated too, so a frozen clock holds every count
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            count_r <= CNT_W'(`RST_CNT8);
        end else if (clk_en_in && (!enabled || state_r == CH_IDLE)) begin
            count_r <= CNT_W'(`RST_CNT8);
        end else if (clk_en_in && tick) begin
            if (period_end) begin
                count_r <= CNT_W'(`RST_CNT8);
            end else begin
                count_r <= count_r + CNT_W'(`ONE_CNT8);
            end
        end
    end

    // wave: high in the pulse phase, compares the next count value
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            wave_r <= 1'b1;
        end else if (clk_en_in && state_r == CH_IDLE) begin
            wave_r <= 1'b1;
        end else if (clk_en_in && tick) begin
            if (period_end) begin
                wave_r <= 1'b1;
            end else begin
                wave_r <= !((count_r + CNT_W'(`ONE_CNT8)) >= cmp_width_r);
            end
        end
    end

    // pin: disabled parks low; open drain only pulls low
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            p4_7_out    <= 1'b0;
            p4_7_oe_out <= 1'b0;
        end else if (clk_en_in) begin
            p4_7_out <= enabled && (wave_r ^ ctrl_r[`CTRL_POL_BIT]);
            if (ctrl_r[`CTRL_DRIVE_BIT]) begin
                p4_7_oe_out <= 1'b1;
            end else begin
                p4_7_oe_out <= !(enabled && (wave_r ^ ctrl_r[`CTRL_POL_BIT]));
            end
        end
    end

    // channel checks
    a_count_clear: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (clk_en_in && period_end && enabled && state_r == CH_RUN)
        |=> (count_r == CNT_W'(`RST_CNT8) && wave_r))
        else $error("count not cleared at period end");
    a_low_phase: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (clk_en_in && tick && !period_end && state_r == CH_RUN && enabled
         && (count_r + CNT_W'(`ONE_CNT8)) >= cmp_width_r) |=> !wave_r)
        else $error("wave not low after width");
    a_cmp_hold: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (state_r == CH_RUN && !reload) |=> $stable(cmp_period_r))
        else $error("comparator changed mid period");
    a_enable_load: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (clk_en_in && state_r == CH_IDLE && enabled)
        |=> (cmp_width_r == $past(width_r)))
        else $error("enable did not load comparators");
    a_period_load: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (clk_en_in && period_end)
        |=> (cmp_period_r == $past(period_r)))
        else $error("period end did not load comparator");
    a_tick_pulse: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (clk_en_in && tick) |=> !tick)
        else $error("prescaler tick longer than one cycle");
    a_idle_wave: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (clk_en_in && state_r == CH_IDLE) |=> wave_r)
        else $error("idle channel not parked in pulse phase");
    a_disable_idle: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (clk_en_in && !enabled) |=> (state_r == CH_IDLE))
        else $error("disabled channel still running");
    a_count_free: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (clk_en_in && tick && !period_end && enabled && state_r == CH_RUN)
        |=> (count_r == $past(count_r) + CNT_W'(`ONE_CNT8)))
        else $error("counter did not advance");

    // pin checks
    a_pin_polarity: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (clk_en_in && $past(clk_en_in)) |-> (p4_7_out ==
        ($past(enabled) && ($past(wave_r) ^ $past(ctrl_r[`CTRL_POL_BIT])))))
        else $error("pin polarity wrong");
    a_drive_pp: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (clk_en_in && ctrl_r[`CTRL_DRIVE_BIT]) |=> p4_7_oe_out)
        else $error("push-pull not driving");
    a_open_drain: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (clk_en_in && !ctrl_r[`CTRL_DRIVE_BIT]) |=> (p4_7_oe_out == !p4_7_out))
        else $error("open drain enable not inverse of value");
    a_disable_park: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (clk_en_in && !enabled) |=> !p4_7_out)
        else $error("disabled output not low");

    // register bus checks
    a_apb_wait: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (clk_en_in && psel_in && penable_in && !pready_out) |=> pready_out)
        else $error("access not answered after one wait");
    a_ready_pulse: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (clk_en_in && pready_out) |=> !pready_out)
        else $error("ready held longer than one cycle");
    a_err_ready: assert property (@(posedge core_clk_in) disable iff (reset_in)
        pslverr_out |-> pready_out)
        else $error("slave error without ready");
    a_unmapped_err: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (clk_en_in && psel_in && penable_in && !pready_out && !hit_any) |=> pslverr_out)
        else $error("unmapped access not refused");
    a_write_ignored: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (clk_en_in && wr_acc && !hit_any) |=> $stable(ctrl_r))
        else $error("unmapped write changed control");
    a_write_period: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (clk_en_in && wr_acc && hit_period)
        |=> (period_r == $past(pwdata_in[CNT_W-1:0])))
        else $error("period write did not land");
    a_read_ctrl: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (clk_en_in && rd_acc && !pready_out && hit_ctrl)
        |=> (prdata_out == {24'h00_0000, $past(ctrl_r)}))
        else $error("control read data wrong");
    a_read_period: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (clk_en_in && rd_acc && !pready_out && hit_period)
        |=> (prdata_out[7:0] == $past(period_r)))
        else $error("period read data wrong");
    a_read_width: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (clk_en_in && rd_acc && !pready_out && hit_width)
        |=> (prdata_out[7:0] == $past(width_r)))
        else $error("width read data wrong");
endmodule // programmable_period_pwm

// [shared/pwm_map.svh]
`ifndef PWM_MAP_SVH
`define PWM_MAP_SVH
// register word indices; the bus byte address is the index times four
`define IDX_CTRL        8'ha1
`define IDX_PERIOD      8'haa
`define IDX_WIDTH       8'hab
`define IDX_DIV_LO      8'hb3
`define IDX_DIV_HI      8'hb4
`define ADDR_SHIFT      2
// shared control register fields, reset values and step constants
`define CTRL_POL_BIT    6
`define CTRL_EN_BIT     5
`define CTRL_DRIVE_BIT  4
`define RST_BYTE        8'h00
`define RST_DIV         16'h0000
`define RST_CNT8        8'h00
`define ONE_CNT8        8'h01
`define ONE_DIV         16'h0001
`endif

// [shared/pwm_pkg.sv]
package pwm_pkg;
    typedef enum logic [0:0] {
        CH_IDLE = 1'b0,
        CH_RUN  = 1'b1
    } ch_state_t;
endpackage

// [src/half_rate_divider.sv]
`timescale 1ns/1ps
`include "pwm_map.svh"
module half_rate_divider #(
    parameter int DIV_W = 16
) (
    // clock and control
    input  wire logic             core_clk_in,
    input  wire logic             reset_in,
    input  wire logic             clk_en_in,
    input  wire logic             run_in,
    input  wire logic             reload_in,
    input  wire logic [DIV_W-1:0] div_in,
    // tick out
    output logic                  tick_out
);
    logic             half_r;
    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] div_r;

    // system clock halved feeds the prescaler
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            half_r <= 1'b0;
        end else if (clk_en_in && !run_in) begin
            half_r <= 1'b0;
        end else if (clk_en_in) begin
            half_r <= ~half_r;
        end
    end

    // divisor is only taken at reload, so a mid-period write never tears a count
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            div_r <= DIV_W'(`RST_DIV);
        end else if (clk_en_in && reload_in) begin
            div_r <= div_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            cnt_r    <= DIV_W'(`RST_DIV);
            tick_out <= 1'b0;
        end else if (clk_en_in && !run_in) begin
            cnt_r    <= DIV_W'(`RST_DIV);
            tick_out <= 1'b0;
        end else if (clk_en_in) begin
            tick_out <= 1'b0;
            if (half_r) begin
                if (cnt_r >= div_r) begin
                    cnt_r    <= DIV_W'(`RST_DIV);
                    tick_out <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + DIV_W'(`ONE_DIV);
                end
            end
        end
    end
endmodule // half_rate_divider

// [verification/test_programmable_period_pwm.sv]
`timescale 1ns/1ps
`include "pwm_map.svh"
module test_programmable_period_pwm;
    logic        core_clk_in, reset_in, clk_en_in, psel_in, penable_in, pwrite_in;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out;
    logic        pready_out, pslverr_out, p4_7_out, p4_7_oe_out;
    int          n_fail, n_compared, cyc, act, per, t0;
    logic [15:0] seed;
    logic [7:0]  p, w;
    logic [33:0] note;
    logic [33:0] notes[$];
    logic [7:0]  regs[5] = '{`IDX_CTRL, `IDX_PERIOD, `IDX_WIDTH, `IDX_DIV_LO, `IDX_DIV_HI};

    programmable_period_pwm i_programmable_period_pwm (
        .core_clk_in(core_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .p4_7_out(p4_7_out), .p4_7_oe_out(p4_7_oe_out));

    initial begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in) cyc <= cyc + 1;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // the expected answer is noted before the request goes out
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                       input logic err, input logic [7:0] exp);
        int n;
        n = 0;
        notes.push_back({wr, err, 24'h0, exp});
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= {2'b00, idx, 2'b00};
        pwdata_in <= {24'h0, d};
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        @(posedge core_clk_in);
        while (pready_out !== 1'b1 && n < 50) begin
            @(posedge core_clk_in);
            n++;
        end
        if (n >= 50) check("pready", 32'h0, 32'h1);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge core_clk_in);
    endtask

    always @(posedge core_clk_in) begin
        if (psel_in && penable_in && pready_out === 1'b1 && notes.size() > 0) begin
            note = notes.pop_front();
            check("slave error", {31'h0, pslverr_out}, {31'h0, note[32]});
            if (!note[33]) check("read data", prdata_out, note[31:0]);
        end
    end

    task automatic wait_pin(input logic v);
        int n;
        n = 0;
        while (p4_7_out !== v && n < 20000) begin
            @(posedge core_clk_in);
            n++;
        end
        if (n >= 20000) check("pin edge", 32'h0, 32'h1);
    endtask

    // program one setting, then time one whole active phase and one period
    task automatic run(input logic pol, input logic [7:0] pd, input logic [7:0] wd,
                       input logic [15:0] dv);
        apb(1, `IDX_CTRL, 8'h00, 0, 0);
        apb(1, `IDX_PERIOD, pd, 0, 0);
        apb(1, `IDX_WIDTH, wd, 0, 0);
        apb(1, `IDX_DIV_LO, dv[7:0], 0, 0);
        apb(1, `IDX_DIV_HI, dv[15:8], 0, 0);
        apb(1, `IDX_CTRL, {1'b0, pol, 6'h30}, 0, 0);
        // the first pulse after enable is stretched because the prescaler only starts once the channel is in CH_RUN; skip it
        wait_pin(~pol);
        wait_pin(pol);
        wait_pin(~pol);
        t0 = cyc;
        wait_pin(pol);
        act = cyc - t0;
        wait_pin(~pol);
        per = cyc - t0;
        check("active phase", act, wd * 2 * (dv + 1));
        check("period", per, (pd + 1) * 2 * (dv + 1));
        check("push-pull enable", {31'h0, p4_7_oe_out}, 32'h1);
        $display("test run pol %0d period %0d width %0d div %0d done", pol, pd, wd, dv);
    endtask

    initial begin
        n_fail = 0;
        n_compared = 0;
        seed = 16'hf93b;
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        clk_en_in = 1'b1;
        reset_in = 1'b1;
        repeat (16) @(posedge core_clk_in);
        reset_in <= 1'b0;
        @(posedge core_clk_in);
        check("pin after reset", {p4_7_out, p4_7_oe_out}, 32'h0);
        foreach (regs[i]) apb(0, regs[i], 8'h00, 0, 8'h00);
        apb(1, 8'h90, 8'h5a, 1, 8'h00);
        apb(0, 8'h90, 8'h00, 1, 8'h00);
        apb(1, `IDX_CTRL, 8'h50, 0, 0);
        apb(0, `IDX_CTRL, 8'h00, 0, 8'h50);
        for (int i = 1; i < 5; i++) begin
            seed = lfsr(seed);
            apb(1, regs[i], seed[7:0], 0, 0);
            apb(0, regs[i], 8'h00, 0, seed[7:0]);
        end
        $display("test registers done");
        run(1'b0, 8'h03, 8'h01, 16'h0000);
        run(1'b1, 8'h04, 8'h01, 16'h0100);
        seed = lfsr(seed);
        p = 8'h02 + seed[3:0];
        w = 8'h01 + (seed[7:4] % (p - 8'h01));
        run(1'b0, p, w, {14'h0, seed[9:8]});
        run(1'b0, 8'h05, 8'h02, 16'h0001);
        // new values written in mid-period must wait for its end
        wait_pin(1'b0);
        t0 = cyc;
        apb(1, `IDX_WIDTH, 8'h04, 0, 0);
        apb(1, `IDX_PERIOD, 8'h09, 0, 0);
        wait_pin(1'b1);
        check("old low phase", cyc - t0, 32'd16);
        t0 = cyc;
        wait_pin(1'b0);
        check("new high phase", cyc - t0, 32'd16);
        wait_pin(1'b1);
        check("new period", cyc - t0, 32'd40);
        $display("test reload done");
        apb(1, `IDX_CTRL, 8'h20, 0, 0);
        repeat (40) begin
            @(posedge core_clk_in);
            check("open drain enable", p4_7_oe_out, {31'h0, ~p4_7_out});
        end
        // clock enable low: pin and its enable must hold over a whole period
        clk_en_in <= 1'b0;
        @(posedge core_clk_in);
        t0 = {p4_7_out, p4_7_oe_out};
        repeat (48) begin
            @(posedge core_clk_in);
            check("frozen pin", {p4_7_out, p4_7_oe_out}, t0);
        end
        clk_en_in <= 1'b1;
        apb(1, `IDX_CTRL, 8'h00, 0, 0);
        repeat (4) @(posedge core_clk_in);
        check("disabled pin", {31'h0, p4_7_out}, 32'h0);
        $display("test drive and disable done");
        report_and_stop();
    end

    initial begin
        #(4 * 40000);
        n_fail++;
        report_and_stop();
    end
endmodule // test_programmable_period_pwm
